// [rtl/ccsp_pkg.sv]
package ccsp_pkg;
  // Clock and start-up timing
  localparam int CLK_FREQ_KHZ    = 100000;
  localparam int POR_TIME_MS     = 10;
  // Longest time; ms times kHz gives the cycle count exactly, with no rounding
  localparam int POR_CYCLES_DFLT = POR_TIME_MS * CLK_FREQ_KHZ;

  // Stored images and register space
  localparam int OTP_IMAGES = 4;
  localparam int REG_COUNT  = 256;

  // Bus addresses, 7-bit form of 8'hD4 and 8'hD0
  localparam logic [6:0] BUS_ADDR_PRIMARY   = 7'h6A;
  localparam logic [6:0] BUS_ADDR_SECONDARY = 7'h68;

  // Register layout
  localparam logic [7:0] ADDR_CFG_REG     = 8'h00;
  localparam int         ADDR_SEL_BIT     = 0;
  localparam logic [7:0] OTP_CMD_REG      = 8'h72;
  localparam int         SAVE_BIT         = 3;
  localparam int         RESTORE_BIT      = 0;
  localparam logic [7:0] CMD_STROBE_MASK  = 8'h09;
  localparam logic [7:0] REG_RESET        = 8'h00;
  localparam logic [7:0] REG_LAST         = 8'hFF;

  // Bit counting within a byte
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] RD_LAST_BIT = 4'h7;

  typedef logic [7:0] ccsp_byte_t;
  typedef logic [1:0] ccsp_img_t;

  typedef enum logic [3:0] {
    ST_POR  = 4'h1,
    ST_LOAD = 4'h2,
    ST_RUN  = 4'h4,
    ST_SAVE = 4'h8
  } ccsp_sys_t;

  typedef enum logic [6:0] {
    BS_IDLE = 7'h01,
    BS_ADDR = 7'h02,
    BS_REG  = 7'h04,
    BS_WR   = 7'h08,
    BS_RD   = 7'h10,
    BS_SACK = 7'h20,
    BS_MACK = 7'h40
  } ccsp_bus_t;
endpackage

// [rtl/ccsp_pin_if.sv]
`timescale 1ns/1ps
interface ccsp_pin_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport drv (output scl, sda, scl_rise, scl_fall, start, stop);
  modport snk (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface

// [rtl/ccsp_pin_sync.sv]
`timescale 1ns/1ps
module ccsp_pin_sync #(
  parameter int STAGES = 2
) (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  input  wire logic scl_pin_in,
  input  wire logic sda_pin_in,
  ccsp_pin_if.drv   pins
);
  import ccsp_pkg::*;

  if (STAGES < 2) begin : g_bad_stages
    $error("ccsp_pin_sync needs at least two stages");
  end

  logic [STAGES-1:0] scl_chain;
  logic [STAGES-1:0] sda_chain;
  logic              scl_prev;
  logic              sda_prev;
  wire               scl_s = scl_chain[STAGES-1];
  wire               sda_s = sda_chain[STAGES-1];

  // Pins idle high under pull-ups, so reset to high avoids a false edge
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      scl_chain <= '1;
      sda_chain <= '1;
      scl_prev  <= 1'b1;
      sda_prev  <= 1'b1;
    end else if (ce_in) begin
      scl_chain <= {scl_chain[STAGES-2:0], scl_pin_in};
      sda_chain <= {sda_chain[STAGES-2:0], sda_pin_in};
      scl_prev  <= scl_s;
      sda_prev  <= sda_s;
    end
  end

  assign pins.scl      = scl_s;
  assign pins.sda      = sda_s;
  assign pins.scl_rise = scl_s & ~scl_prev;
  assign pins.scl_fall = ~scl_s & scl_prev;
  assign pins.start    = scl_s & scl_prev & sda_prev & ~sda_s;
  assign pins.stop     = scl_s & scl_prev & ~sda_prev & sda_s;
endmodule

// [rtl/ccsp_top.sv]
`timescale 1ns/1ps
module ccsp_top #(
  parameter int POR_CYCLES = ccsp_pkg::POR_CYCLES_DFLT
) (
  input  wire logic                 clock_in,
  input  wire logic                 rst_in,
  input  wire logic                 ce_in,
  input  wire logic                 cfg_pick0_bus_clock_pin_in,
  input  wire logic                 cfg_pick1_bus_data_pin_in,
  output logic                      cfg_pick1_bus_data_pin_out,
  output logic                      cfg_pick1_bus_data_pin_oe_out,
  input  wire logic                 otp_prog_en_in,
  input  wire ccsp_pkg::ccsp_img_t  otp_prog_image_in,
  input  wire ccsp_pkg::ccsp_byte_t otp_prog_addr_in,
  input  wire ccsp_pkg::ccsp_byte_t otp_prog_data_in,
  input  wire ccsp_pkg::ccsp_byte_t cfg_rd_addr_in,
  output ccsp_pkg::ccsp_byte_t      cfg_rd_data_out,
  output logic                      ready_out,
  output logic                      otp_busy_out,
  output ccsp_pkg::ccsp_img_t       image_sel_out
);
  import ccsp_pkg::*;

  if (POR_CYCLES < 1) begin : g_bad_por
    $error("ccsp_top needs POR_CYCLES of at least one");
  end

  ccsp_pin_if pins ();

  ccsp_pin_sync #(
    .STAGES (2)
  ) u_sync (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .scl_pin_in (cfg_pick0_bus_clock_pin_in),
    .sda_pin_in (cfg_pick1_bus_data_pin_in),
    .pins       (pins.drv)
  );

  ccsp_sys_t       sys;
  ccsp_bus_t       bus;
  ccsp_bus_t       after_ack;
  logic [31:0]     por_cnt;
  ccsp_byte_t      idx;
  ccsp_img_t       img;
  ccsp_byte_t      regs [REG_COUNT];
  ccsp_byte_t      wbuf [REG_COUNT];
  logic [REG_COUNT-1:0] wmask;
  ccsp_byte_t      otp  [OTP_IMAGES][REG_COUNT];
  ccsp_byte_t      shift;
  ccsp_byte_t      ptr;
  logic [3:0]      bitcnt;
  logic            mack;
  logic            sda_oe;

  // Decode
  wire        bus_evt    = ce_in & ~pins.start & ~pins.stop;
  wire        byte_full  = (bitcnt == BYTE_BITS);
  wire        byte_end   = bus_evt & pins.scl_fall & byte_full;
  wire [6:0]  my_addr    = regs[ADDR_CFG_REG][ADDR_SEL_BIT] ? BUS_ADDR_SECONDARY
                                                           : BUS_ADDR_PRIMARY;
  wire        addr_match = (shift[7:1] == my_addr) & (sys == ST_RUN);
  wire        wr_done    = byte_end & (bus == BS_WR);
  wire        commit     = ce_in & pins.stop & (|wmask);
  wire        cmd_hit    = commit & wmask[OTP_CMD_REG];
  wire        go_save    = cmd_hit & wbuf[OTP_CMD_REG][SAVE_BIT];
  wire        go_restore = cmd_hit & wbuf[OTP_CMD_REG][RESTORE_BIT] & ~go_save;
  wire        load_last  = (sys == ST_LOAD) & (idx == REG_LAST);
  wire        save_last  = (sys == ST_SAVE) & (idx == REG_LAST);
  wire        por_done   = (sys == ST_POR) & (por_cnt == 32'(POR_CYCLES - 1));
  wire        drive_low  = (bus == BS_SACK) | ((bus == BS_RD) & ~shift[7]);
  wire        rd_next    = bus_evt & pins.scl_fall &
                           (((bus == BS_SACK) & (after_ack == BS_RD)) |
                            ((bus == BS_MACK) & mack));

  // reset timer, then load from store
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sys     <= ST_POR;
      por_cnt <= '0;
      idx     <= '0;
      img     <= '0;
    end else if (ce_in) begin
      unique case (sys)
        ST_POR: begin
          por_cnt <= por_cnt + 32'h1;
          if (por_done) begin
            sys <= ST_LOAD;
            idx <= '0;
            // Strap shares the bus pins, caught as reset ends
            img <= {pins.sda, pins.scl};
          end
        end
        ST_LOAD: begin
          idx <= idx + 8'h01;
          if (load_last) begin
            sys <= ST_RUN;
          end
        end
        ST_RUN: begin
          idx <= '0;
          if (go_save) begin
            sys <= ST_SAVE;
          end else if (go_restore) begin
            sys <= ST_LOAD;
          end
        end
        ST_SAVE: begin
          idx <= idx + 8'h01;
          if (save_last) begin
            sys <= ST_RUN;
          end
        end
      endcase
    end
  end

  // factory image port and save path
  always_ff @(posedge clock_in) begin
    if (ce_in) begin
      if (otp_prog_en_in) begin
        otp[otp_prog_image_in][otp_prog_addr_in] <= otp_prog_data_in;
      end else if (sys == ST_SAVE) begin
        otp[img][idx] <= regs[idx];
      end
    end
  end

  // live registers are cleared by reset
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (ce_in) begin
      if (sys == ST_LOAD) begin
        regs[idx] <= otp[img][idx];
      end else if (commit) begin
        // all buffered bytes land together; bus overwrite
        for (int i = 0; i < REG_COUNT; i++) begin
          if (wmask[i]) begin
            // Command bits are strobes and read back as zero
            regs[i] <= (i == int'(OTP_CMD_REG)) ? (wbuf[i] & ~CMD_STROBE_MASK) : wbuf[i];
          end
        end
      end
    end
  end

  // Write buffer; commit and a new byte never share a cycle
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wmask <= '0;
    end else if (commit) begin
      wmask <= '0;
    end else if (wr_done) begin
      wbuf[ptr]  <= shift;
      wmask[ptr] <= 1'b1;
    end
  end

  // Byte-level slave engine
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      bus       <= BS_IDLE;
      after_ack <= BS_IDLE;
      bitcnt    <= '0;
      shift     <= '0;
      ptr       <= '0;
      mack      <= 1'b0;
    end else if (ce_in) begin
      if (pins.start) begin
        bus    <= BS_ADDR;
        bitcnt <= '0;
      end else if (pins.stop) begin
        bus <= BS_IDLE;
      end else begin
        unique case (bus)
          BS_IDLE: begin
            bitcnt <= '0;
          end
          BS_ADDR, BS_REG, BS_WR: begin
            if (pins.scl_rise && !byte_full) begin
              shift  <= {shift[6:0], pins.sda};
              bitcnt <= bitcnt + 4'h1;
            end else if (byte_end) begin
              bitcnt <= '0;
              bus    <= BS_SACK;
              if (bus == BS_ADDR) begin
                if (!addr_match) begin
                  bus <= BS_IDLE;
                end
                after_ack <= shift[0] ? BS_RD : BS_REG;
              end else if (bus == BS_REG) begin
                ptr       <= shift;
                after_ack <= BS_WR;
              end else begin
                ptr       <= ptr + 8'h01;
                after_ack <= BS_WR;
              end
            end
          end
          BS_SACK: begin
            if (pins.scl_fall) begin
              bus <= after_ack;
            end
          end
          BS_RD: begin
            if (pins.scl_fall) begin
              shift  <= {shift[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == RD_LAST_BIT) begin
                bus    <= BS_MACK;
                bitcnt <= '0;
              end
            end
          end
          BS_MACK: begin
            if (pins.scl_rise) begin
              mack <= ~pins.sda;
            end else if (pins.scl_fall) begin
              bus <= mack ? BS_RD : BS_IDLE;
            end
          end
        endcase
        if (rd_next) begin
          shift <= regs[ptr];
          ptr   <= ptr + 8'h01;
        end
      end
    end
  end

  // acknowledge and read data, one flop behind the engine
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sda_oe <= 1'b0;
    end else if (ce_in) begin
      sda_oe <= drive_low;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cfg_rd_data_out <= '0;
    end else if (ce_in) begin
      cfg_rd_data_out <= regs[cfg_rd_addr_in];
    end
  end

  // Open drain: only ever pulls low
  assign cfg_pick1_bus_data_pin_out    = 1'b0;
  assign cfg_pick1_bus_data_pin_oe_out = sda_oe;
  assign ready_out                     = (sys == ST_RUN);
  assign otp_busy_out                  = (sys == ST_LOAD) | (sys == ST_SAVE);
  assign image_sel_out                 = img;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  chk_por_expire: assert property (
    por_done && ce_in |=> sys == ST_LOAD)
    else $error("reset timer did not hand over to loading");

  chk_por_bound: assert property (
    sys == ST_POR |-> por_cnt < 32'(POR_CYCLES))
    else $error("reset timer ran past its limit");

  chk_load_done: assert property (
    load_last && ce_in |=> sys == ST_RUN && ready_out)
    else $error("load did not finish into operation");

  chk_quiet_busy: assert property (
    sys != ST_RUN |-> !cfg_pick1_bus_data_pin_oe_out)
    else $error("data pin driven while not operating");

  chk_ack_own: assert property (
    bus == BS_SACK && ce_in |=> cfg_pick1_bus_data_pin_oe_out)
    else $error("acknowledge not driven");

  chk_nack_foreign: assert property (
    byte_end && bus == BS_ADDR && !addr_match |=> bus == BS_IDLE)
    else $error("foreign address answered");

  chk_msb_first: assert property (
    bus == BS_RD && ce_in |=> sda_oe == !$past(shift[7]))
    else $error("read bit order wrong");

  chk_ptr_ascend: assert property (
    wr_done |=> ptr == $past(ptr) + 8'h01)
    else $error("pointer did not advance");

  chk_commit_stop: assert property (
    sys == ST_RUN && !commit && ce_in |=> $stable(regs[ADDR_CFG_REG]))
    else $error("register changed before stop");

  chk_cmd_start: assert property (
    (go_save && ce_in |=> sys == ST_SAVE) and (go_restore && ce_in |=> sys == ST_LOAD))
    else $error("save or restore not started");

  cov_read_burst:  cover property (bus == BS_MACK ##1 bus == BS_MACK [*2] ##[1:40] bus == BS_RD);
  cov_commit:      cover property (commit);
  cov_save:        cover property (sys == ST_SAVE ##[1:300] sys == ST_RUN);
  cov_restore:     cover property (go_restore);
endmodule

// [verif/ccsp_bus_master.sv]
`timescale 1ns/1ps
module ccsp_bus_master (
  input  wire logic clock_in,
  input  wire logic oe_in,
  output logic      scl_out,
  output logic      sda_out
);
  logic sda_q;

  // Pull-up holds the line high unless someone pulls it low
  assign sda_out = sda_q & ~oe_in;

  initial begin
    scl_out = 1'b1;
    sda_q   = 1'b1;
  end

  // Half of an 80 ns link clock period
  task automatic ph();
    repeat (4) @(posedge clock_in);
  endtask

  task automatic start();
    ph();
    sda_q <= 1'b1;
    ph();
    scl_out <= 1'b1;
    ph();
    sda_q <= 1'b0;
    ph();
    scl_out <= 1'b0;
  endtask

  task automatic stop();
    ph();
    sda_q <= 1'b0;
    ph();
    scl_out <= 1'b1;
    ph();
    sda_q <= 1'b1;
    ph();
  endtask

  // Line sampled before the edge's own updates land
  task automatic xbit(input logic b, output logic r);
    sda_q <= b;
    ph();
    scl_out <= 1'b1;
    ph();
    r = sda_out;
    scl_out <= 1'b0;
  endtask

  task automatic xbyte(input logic [7:0] d, input logic ak,
                       output logic [7:0] q, output logic ar);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], q[i]);
    end
    xbit(ak, ar);
  endtask
endmodule

// [verif/test_clock_gen_config_serial_port.sv]
`timescale 1ns/1ps
module test_clock_gen_config_serial_port;
  import ccsp_pkg::*;
  localparam int         POR = 300;
  localparam ccsp_byte_t DP  = {BUS_ADDR_PRIMARY, 1'b0};
  localparam ccsp_byte_t DS  = {BUS_ADDR_SECONDARY, 1'b0};

  logic       clock_in;
  logic       rst_in;
  logic       ce_in;
  logic       scl;
  logic       sda;
  logic       pin_out;
  logic       oe;
  logic       otp_en;
  ccsp_img_t  otp_img;
  ccsp_byte_t otp_addr;
  ccsp_byte_t otp_data;
  ccsp_byte_t rd_addr;
  ccsp_byte_t rd_data;
  logic       ready;
  logic       busy;
  ccsp_img_t  img_sel;
  ccsp_byte_t q;
  ccsp_byte_t d;
  logic       ar;
  ccsp_byte_t wd [3];
  ccsp_byte_t rdv [3];
  int         err_count;
  int         n_tests;
  int         cyc = 0;
  int         r0;
  int         c;
  // Register, written byte, expected read
  ccsp_byte_t rows [4][3] = '{'{8'h20, 8'h00, 8'h00}, '{8'h21, 8'hFF, 8'hFF},
                              '{8'h7F, 8'h96, 8'h96}, '{8'hFE, 8'h3C, 8'h3C}};

  ccsp_top #(.POR_CYCLES(POR)) ccsp_top_inst (
    .clock_in                     (clock_in),
    .rst_in                       (rst_in),
    .ce_in                        (ce_in),
    .cfg_pick0_bus_clock_pin_in   (scl),
    .cfg_pick1_bus_data_pin_in    (sda),
    .cfg_pick1_bus_data_pin_out   (pin_out),
    .cfg_pick1_bus_data_pin_oe_out(oe),
    .otp_prog_en_in               (otp_en),
    .otp_prog_image_in            (otp_img),
    .otp_prog_addr_in             (otp_addr),
    .otp_prog_data_in             (otp_data),
    .cfg_rd_addr_in               (rd_addr),
    .cfg_rd_data_out              (rd_data),
    .ready_out                    (ready),
    .otp_busy_out                 (busy),
    .image_sel_out                (img_sel)
  );

  ccsp_bus_master ccsp_bus_master_inst (
    .clock_in(clock_in),
    .oe_in   (oe),
    .scl_out (scl),
    .sda_out (sda)
  );

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  always @(posedge clock_in) cyc <= cyc + 1;

  // Factory image contents, chosen to keep command bits clear
  function automatic ccsp_byte_t fv(input ccsp_byte_t a);
    return a ^ 8'hA4;
  endfunction

  task automatic stop_test();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input ccsp_byte_t e, input ccsp_byte_t g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wait_rdy();
    c = 0;
    while (ready !== 1'b1 && c <= 2000) begin
      @(posedge clock_in);
      c++;
    end
    if (c > 2000) begin
      chk("ready_wait", 8'h01, 8'h00);
      stop_test();
    end
  endtask

  task automatic sread(input ccsp_byte_t a, output ccsp_byte_t v);
    @(posedge clock_in);
    rd_addr <= a;
    repeat (2) @(posedge clock_in);
    v = rd_data;
  endtask

  task automatic sendb(input ccsp_byte_t b);
    ccsp_bus_master_inst.xbyte(b, 1'b1, q, ar);
    chk("ack", 8'h00, {7'h00, ar});
    // Acknowledge still driven here; the pin output value is tied low at all times
    chk("pin_lvl", 8'h00, {7'h00, pin_out});
  endtask

  task automatic nack_addr(input ccsp_byte_t dv);
    ccsp_bus_master_inst.start();
    ccsp_bus_master_inst.xbyte(dv, 1'b1, q, ar);
    chk("no_ack", 8'h01, {7'h00, ar});
    ccsp_bus_master_inst.stop();
  endtask

  task automatic wr(input ccsp_byte_t dv, input ccsp_byte_t ra, input int n, input bit stp);
    ccsp_bus_master_inst.start();
    sendb(dv);
    sendb(ra);
    for (int i = 0; i < n; i++) begin
      sendb(wd[i]);
    end
    if (stp) begin
      ccsp_bus_master_inst.stop();
    end
  endtask

  task automatic rd(input ccsp_byte_t dv, input ccsp_byte_t ra, input int n, input bit rnd);
    if (rnd) begin
      ccsp_bus_master_inst.start();
      sendb(dv);
      sendb(ra);
    end
    ccsp_bus_master_inst.start();
    sendb(dv | 8'h01);
    for (int i = 0; i < n; i++) begin
      ccsp_bus_master_inst.xbyte(8'hFF, i == n - 1, rdv[i], ar);
    end
    ccsp_bus_master_inst.stop();
  endtask

  initial begin
    rst_in    = 1'b1;
    ce_in     = 1'b1;
    otp_en    = 1'b0;
    otp_img   = 2'h3;
    otp_addr  = 8'h00;
    otp_data  = 8'h00;
    rd_addr   = 8'h00;
    err_count = 0;
    n_tests   = 0;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    r0 = cyc;
    // Fill image 3 while the reset timer runs
    for (int a = 0; a < 256; a++) begin
      @(posedge clock_in);
      otp_en   <= 1'b1;
      otp_addr <= a[7:0];
      otp_data <= fv(a[7:0]);
    end
    @(posedge clock_in);
    otp_en <= 1'b0;
    repeat (50) @(posedge clock_in);
    chk("busy_load", 8'h01, {7'h00, busy});
    nack_addr(DP);
    wait_rdy();
    chk("por_len", 8'h01, {7'h00, (cyc - r0) >= POR && (cyc - r0) <= POR + 262});
    chk("img_sel", 8'h03, {6'h00, img_sel});
    sread(8'h10, d);
    chk("loaded", fv(8'h10), d);
    for (int i = 0; i < 4; i++) begin
      wd[0] = rows[i][1];
      wr(DP, rows[i][0], 1, 1'b1);
      sread(rows[i][0], d);
      chk("side_rd", rows[i][2], d);
      rd(DP, rows[i][0], 1, 1'b1);
      chk("bus_rd", rows[i][2], rdv[0]);
    end
    wd = '{8'h11, 8'h22, 8'h33};
    wr(DP, 8'h30, 3, 1'b0);
    sread(8'h30, d);
    chk("held", fv(8'h30), d);
    ccsp_bus_master_inst.stop();
    for (int j = 0; j < 3; j++) begin
      sread(8'h30 + j[7:0], d);
      chk("commit", wd[j], d);
    end
    rd(DP, 8'h30, 3, 1'b1);
    for (int j = 0; j < 3; j++) begin
      chk("blk_rd", wd[j], rdv[j]);
    end
    rd(DP, 8'h00, 2, 1'b0);
    chk("cur_rd0", fv(8'h33), rdv[0]);
    chk("cur_rd1", fv(8'h34), rdv[1]);
    nack_addr(DS);
    wd[0] = 8'h01 << ADDR_SEL_BIT;
    wr(DP, ADDR_CFG_REG, 1, 1'b1);
    nack_addr(DP);
    wd[0] = 8'h00;
    wr(DS, ADDR_CFG_REG, 1, 1'b1);
    wd[0] = 8'h77;
    wr(DP, 8'h10, 1, 1'b1);
    wd[0] = 8'h01 << RESTORE_BIT;
    wr(DP, OTP_CMD_REG, 1, 1'b1);
    chk("busy_rst", 8'h01, {7'h00, busy});
    nack_addr(DP);
    wait_rdy();
    sread(8'h10, d);
    chk("restore", fv(8'h10), d);
    wd[0] = 8'h55;
    wr(DP, 8'h10, 1, 1'b1);
    wd[0] = 8'h01 << SAVE_BIT;
    wr(DP, OTP_CMD_REG, 1, 1'b1);
    chk("busy_save", 8'h01, {7'h00, busy});
    wait_rdy();
    sread(OTP_CMD_REG, d);
    chk("cmd_clear", 8'h00, d);
    wd[0] = 8'h66;
    wr(DP, 8'h11, 1, 1'b1);
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    chk("rst_ready", 8'h00, {7'h00, ready});
    chk("rst_oe", 8'h00, {7'h00, oe});
    chk("rst_pin", 8'h00, {7'h00, pin_out});
    rst_in <= 1'b0;
    // Clock enable low must freeze the reset timer well past its length
    ce_in  <= 1'b0;
    repeat (POR + 100) @(posedge clock_in);
    chk("ce_ready", 8'h00, {7'h00, ready});
    chk("ce_busy", 8'h00, {7'h00, busy});
    ce_in <= 1'b1;
    wait_rdy();
    sread(8'h10, d);
    chk("saved", 8'h55, d);
    sread(8'h11, d);
    chk("volatile", fv(8'h11), d);
    stop_test();
  end
endmodule
